// file: core/fb_timing_pkg.sv
// Package: constants and types for the fieldbus timing and hot-standby block
package fb_timing_pkg;
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned MS_NS          = 1_000_000;
    localparam int unsigned CLK_NS         = 8;
    localparam int unsigned CYC_PER_MS     = MS_NS / CLK_NS;
    localparam logic [15:0] SYN_BITS       = 16'h0021;
    localparam logic [15:0] SM_BASE        = 16'h0002;
    localparam logic [15:0] TSET_MIN       = 16'h0001;
    localparam logic [15:0] TSET_MAX       = 16'h01EE;
    localparam logic [15:0] MIN_TSDR_MIN   = 16'h000B;
    localparam logic [15:0] MIN_TSDR_MAX   = 16'h03FF;
    localparam logic [15:0] MAX_TSDR_MIN   = 16'h0025;
    localparam logic [15:0] MAX_TSDR_MAX   = 16'hFFF5;
    localparam logic [7:0]  CMD_RATE_MIN   = 8'h02;
    localparam logic [7:0]  CMD_RATE_MAX   = 8'h14;
    localparam logic [7:0]  RETRY_MIN      = 8'h05;
    // Register word offsets (byte addresses)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_BITRATE   = 8'h08;
    localparam logic [7:0] REG_TSET      = 8'h0C;
    localparam logic [7:0] REG_TQUI      = 8'h10;
    localparam logic [7:0] REG_MIN_TSDR  = 8'h14;
    localparam logic [7:0] REG_MAX_TSDR  = 8'h18;
    localparam logic [7:0] REG_CYCLE     = 8'h1C;
    localparam logic [7:0] REG_WDOG      = 8'h20;
    localparam logic [7:0] REG_HOLDOVER  = 8'h24;
    localparam logic [7:0] REG_DEADTIME  = 8'h28;
    localparam logic [7:0] REG_CMD_RATE  = 8'h2C;
    localparam logic [7:0] REG_RETRY     = 8'h30;
    localparam logic [7:0] REG_IDLE1     = 8'h34;
    localparam logic [7:0] REG_IDLE2     = 8'h38;
    localparam logic [7:0] REG_SLV_WDOG  = 8'h3C;
    localparam logic [7:0] REG_SLV_SEL   = 8'h40;
    // Control bits
    localparam int unsigned CTRL_STANDBY = 0;
    localparam int unsigned CTRL_HOST_OK = 1;
    localparam int unsigned CTRL_ONLINE  = 2;
    // Per-bit-rate defaults: tset, tqui, min_tsdr, max_tsdr; holdover, deadtime and the rest are fixed
    typedef struct packed {
        logic [15:0] tset;
        logic [15:0] tqui;
        logic [15:0] min_tsdr;
        logic [15:0] max_tsdr;
        logic [15:0] cycle_ms;
        logic [15:0] wdog_ms;
        logic [15:0] holdover_ms;
        logic [15:0] deadtime_ms;
        logic [7:0]  cmd_rate_ms;
        logic [7:0]  retry_limit;
    } timing_cfg_type;
    typedef struct packed {
        logic tx_ack_rx;
        logic tx_unconf;
        logic cycle_start;
    } bus_evt_type;
    typedef enum logic [1:0] {HS_ACTIVE, HS_HOLDOVER, HS_OFFLINE, HS_STANDBY} hs_state_type;
    // Arbitrary rate table values; index 0..9 follows rising bit rate
    localparam logic [3:0] RATE_COUNT = 4'hA;
    function automatic timing_cfg_type rate_defaults(input logic [3:0] rate);
        timing_cfg_type c;
        c = '{tset: 16'h0001, tqui: 16'h0000, min_tsdr: 16'h000B, max_tsdr: 16'h003C,
              cycle_ms: 16'h000A, wdog_ms: 16'h0064, holdover_ms: 16'h0258,
              deadtime_ms: 16'h0041, cmd_rate_ms: 8'h0A, retry_limit: 8'h20};
        if (rate >= 4'h7) begin
            c.tset     = 16'h0010;
            c.tqui     = 16'h0009;
            c.min_tsdr = 16'h000B;
            c.max_tsdr = 16'h0320;
        end else if (rate >= 4'h5) begin
            c.tset     = 16'h0001;
            c.max_tsdr = 16'h0064;
        end
        return c;
    endfunction
endpackage

// file: core/fb_ms_timer.sv
// Millisecond countdown timer with restart
`timescale 1ns/1ps
`default_nettype none
module fb_ms_timer #(
    parameter int unsigned CYC_PER_MS = 125000
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [15:0] ms_i,
    output logic             busy_o,
    output logic             done_o
);
    logic [16:0] sub_r;
    logic [15:0] ms_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_r  <= '0;
            ms_r   <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                // First ms one clock short: users restart a clock after done,
                // so start-to-start spacing is exactly ms_i (needs CYC_PER_MS >= 2)
                sub_r  <= 17'(CYC_PER_MS - 2);
                ms_r   <= (ms_i == 16'h0000) ? 16'h0001 : ms_i;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (sub_r != '0) begin
                    sub_r <= sub_r - 17'h00001;
                end else if (ms_r == 16'h0001) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    ms_r  <= ms_r - 16'h0001;
                    sub_r <= 17'(CYC_PER_MS - 1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: core/fb_timing_hot_standby.sv
// Fieldbus master bus timing and hot-standby takeover core
`timescale 1ns/1ps
`default_nettype none
module fb_timing_hot_standby #(
    parameter int unsigned CYC_PER_MS = fb_timing_pkg::CYC_PER_MS,
    parameter int unsigned BIT_CYC    = 4,
    parameter int unsigned SLAVES     = 8,
    parameter int unsigned OUT_W      = 32
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [7:0]                adr_i,
    input  wire logic [31:0]               dat_i,
    output logic [31:0]                    dat_o,
    input  wire logic                      we_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    output logic                           ack_o,
    output logic                           err_o,
    input  wire fb_timing_pkg::bus_evt_type evt_i,
    input  wire logic                      bus_active_i,
    input  wire logic                      host_data_vld_i,
    input  wire logic [OUT_W-1:0]          host_data_i,
    input  wire logic                      sw_confirm_i,
    output logic                           tx_allow_o,
    output logic                           cycle_tick_o,
    output logic                           bus_master_o,
    output logic                           net_online_o,
    output logic                           sw_req_o,
    output logic [OUT_W-1:0]               out_data_o,
    output logic [15:0]                    slave_wdog_o
);
    import fb_timing_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [3:0]     rate_r;
    timing_cfg_type cfg_r;
    logic [2:0]     ctrl_r;
    hs_state_type   hs_r;
    logic [15:0]    slv_wdog_r [SLAVES];
    logic [SLAVES-1:0] slv_set_r;
    logic [7:0]     slv_sel_r;
    logic [15:0]    idle1_w;
    logic [15:0]    idle2_w;
    logic [15:0]    sm_w;
    logic           wr_w;
    logic [7:0]     retry_cnt_r;
    logic [31:0]    rd_w;
    logic           rd_ok_w;

    assign wr_w = cyc_i && stb_i && we_i && !ack_o && !err_o && sel_i == 4'hF;

    // Safety margin from setup and quiet time
    assign sm_w    = SM_BASE + (cfg_r.tset << 1) + cfg_r.tqui;
    assign idle1_w = (SYN_BITS + sm_w > cfg_r.min_tsdr) ? SYN_BITS + sm_w : cfg_r.min_tsdr;
    assign idle2_w = (SYN_BITS + sm_w > cfg_r.max_tsdr) ? SYN_BITS + sm_w : cfg_r.max_tsdr;

    // Out-of-range writes clamp so the timers never see an illegal setting
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_r <= '0;
            cfg_r  <= rate_defaults(4'h0);
            ctrl_r <= '0;
        end else if (wr_w) begin
            case (adr_i)
                REG_CTRL: ctrl_r <= dat_i[2:0];
                REG_BITRATE: begin
                    if (dat_i[3:0] < RATE_COUNT && dat_i[3:0] != rate_r) begin
                        rate_r <= dat_i[3:0];
                        cfg_r  <= rate_defaults(dat_i[3:0]);
                    end
                end
                REG_TSET:     cfg_r.tset <= clamp(dat_i[15:0], TSET_MIN, TSET_MAX);
                REG_TQUI:     cfg_r.tqui <= {8'h00, dat_i[7:0]};
                REG_MIN_TSDR: cfg_r.min_tsdr <= clamp(dat_i[15:0], MIN_TSDR_MIN, MIN_TSDR_MAX);
                REG_MAX_TSDR: cfg_r.max_tsdr <= clamp(dat_i[15:0], MAX_TSDR_MIN, MAX_TSDR_MAX);
                REG_CYCLE:    cfg_r.cycle_ms <= dat_i[15:0];
                REG_WDOG:     cfg_r.wdog_ms <= dat_i[15:0];
                REG_HOLDOVER: cfg_r.holdover_ms <= dat_i[15:0];
                REG_DEADTIME: cfg_r.deadtime_ms <= dat_i[15:0];
                REG_CMD_RATE: begin
                    cfg_r.cmd_rate_ms <= (dat_i[7:0] < CMD_RATE_MIN) ? CMD_RATE_MIN :
                                         (dat_i[7:0] > CMD_RATE_MAX) ? CMD_RATE_MAX : dat_i[7:0];
                end
                REG_RETRY: cfg_r.retry_limit <= (dat_i[7:0] < RETRY_MIN) ? RETRY_MIN : dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Per-slave watchdog store; cleared entry falls back to the default
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slv_sel_r <= '0;
            slv_set_r <= '0;
        end else if (wr_w && adr_i == REG_SLV_SEL) begin
            slv_sel_r <= dat_i[7:0];
        end else if (wr_w && adr_i == REG_SLV_WDOG && slv_sel_r < 8'(SLAVES)) begin
            slv_set_r[slv_sel_r[$clog2(SLAVES)-1:0]] <= dat_i[16];
        end
    end
    always_ff @(posedge clk_i) begin
        if (wr_w && adr_i == REG_SLV_WDOG && slv_sel_r < 8'(SLAVES)) begin
            slv_wdog_r[slv_sel_r[$clog2(SLAVES)-1:0]] <= dat_i[15:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slave_wdog_o <= '0;
        end else if (slv_sel_r < 8'(SLAVES) && slv_set_r[slv_sel_r[$clog2(SLAVES)-1:0]]) begin
            slave_wdog_o <= slv_wdog_r[slv_sel_r[$clog2(SLAVES)-1:0]];
        end else begin
            slave_wdog_o <= cfg_r.wdog_ms;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone read mux and single-cycle answer
    always_comb begin
        rd_w    = '0;
        rd_ok_w = 1'b1;
        case (adr_i)
            REG_CTRL:     rd_w = {29'h0, ctrl_r};
            REG_STATUS:   rd_w = {24'h0, retry_cnt_r[5:0], hs_r};
            REG_BITRATE:  rd_w = {28'h0, rate_r};
            REG_TSET:     rd_w = {16'h0, cfg_r.tset};
            REG_TQUI:     rd_w = {16'h0, cfg_r.tqui};
            REG_MIN_TSDR: rd_w = {16'h0, cfg_r.min_tsdr};
            REG_MAX_TSDR: rd_w = {16'h0, cfg_r.max_tsdr};
            REG_CYCLE:    rd_w = {16'h0, cfg_r.cycle_ms};
            REG_WDOG:     rd_w = {16'h0, cfg_r.wdog_ms};
            REG_HOLDOVER: rd_w = {16'h0, cfg_r.holdover_ms};
            REG_DEADTIME: rd_w = {16'h0, cfg_r.deadtime_ms};
            REG_CMD_RATE: rd_w = {24'h0, cfg_r.cmd_rate_ms};
            REG_RETRY:    rd_w = {24'h0, cfg_r.retry_limit};
            REG_IDLE1:    rd_w = {16'h0, idle1_w};
            REG_IDLE2:    rd_w = {16'h0, idle2_w};
            REG_SLV_WDOG: rd_w = {16'h0, slave_wdog_o};
            REG_SLV_SEL:  rd_w = {24'h0, slv_sel_r};
            default:      rd_ok_w = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o && !err_o && rd_ok_w;
            err_o <= cyc_i && stb_i && !ack_o && !err_o && !rd_ok_w;
            dat_o <= (cyc_i && stb_i && !we_i) ? rd_w : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Inter-frame idle gap in bit times
    logic [15:0] bit_cnt_r;
    logic [7:0]  sub_bit_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_cnt_r  <= '0;
            sub_bit_r  <= '0;
            tx_allow_o <= 1'b0;
        end else if (evt_i.tx_ack_rx) begin
            bit_cnt_r  <= idle1_w;
            sub_bit_r  <= 8'(BIT_CYC - 1);
            tx_allow_o <= 1'b0;
        end else if (evt_i.tx_unconf) begin
            bit_cnt_r  <= idle2_w;
            sub_bit_r  <= 8'(BIT_CYC - 1);
            tx_allow_o <= 1'b0;
        end else if (bit_cnt_r != '0) begin
            if (sub_bit_r != '0) begin
                sub_bit_r <= sub_bit_r - 8'h01;
            end else begin
                sub_bit_r <= 8'(BIT_CYC - 1);
                bit_cnt_r <= bit_cnt_r - 16'h0001;
            end
        end else begin
            tx_allow_o <= bus_master_o;
        end
    end

    // Cyclic exchange pacing
    logic cyc_busy_w;
    logic cyc_done_w;
    fb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_cycle (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (cyc_done_w || (!cyc_busy_w && bus_master_o && !cycle_tick_o)),
        .ms_i    (cfg_r.cycle_ms),
        .busy_o  (cyc_busy_w),
        .done_o  (cyc_done_w)
    );
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cycle_tick_o <= 1'b0;
        end else begin
            cycle_tick_o <= cyc_done_w && bus_master_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hot-standby: holdover, dead time, switch-over requests
    logic hs_start_w;
    logic [15:0] hs_ms_w;
    logic hs_busy_w;
    logic hs_done_w;
    logic quiet_start_w;
    logic dead_busy_w;
    logic dead_done_w;

    assign hs_start_w = (hs_r == HS_ACTIVE && !ctrl_r[CTRL_HOST_OK] && ctrl_r[CTRL_ONLINE]) ||
                        (hs_r == HS_STANDBY && !hs_busy_w);
    assign hs_ms_w    = (hs_r == HS_ACTIVE) ? cfg_r.holdover_ms : {8'h00, cfg_r.cmd_rate_ms};
    fb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_hs (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (hs_start_w),
        .ms_i    (hs_ms_w),
        .busy_o  (hs_busy_w),
        .done_o  (hs_done_w)
    );
    // Restarts on any bus activity, so done means a continuous quiet span
    assign quiet_start_w = bus_active_i || (hs_r != HS_STANDBY) || (!dead_busy_w && !dead_done_w);
    fb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_dead (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (quiet_start_w && !(dead_done_w && !bus_active_i)),
        .ms_i    (cfg_r.deadtime_ms),
        .busy_o  (dead_busy_w),
        .done_o  (dead_done_w)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_r        <= HS_OFFLINE;
            retry_cnt_r <= '0;
            sw_req_o    <= 1'b0;
        end else begin
            sw_req_o <= 1'b0;
            case (hs_r)
                HS_OFFLINE: begin
                    retry_cnt_r <= '0;
                    if (ctrl_r[CTRL_STANDBY]) hs_r <= HS_STANDBY;
                    else if (ctrl_r[CTRL_ONLINE] && ctrl_r[CTRL_HOST_OK]) hs_r <= HS_ACTIVE;
                end
                HS_ACTIVE: begin
                    if (!ctrl_r[CTRL_ONLINE]) hs_r <= HS_OFFLINE;
                    else if (!ctrl_r[CTRL_HOST_OK]) hs_r <= HS_HOLDOVER;
                end
                HS_HOLDOVER: begin
                    if (ctrl_r[CTRL_HOST_OK]) hs_r <= HS_ACTIVE;
                    else if (hs_done_w) hs_r <= HS_OFFLINE;
                end
                HS_STANDBY: begin
                    if (!ctrl_r[CTRL_STANDBY]) begin
                        hs_r <= HS_OFFLINE;
                    end else if (sw_confirm_i || dead_done_w ||
                                 retry_cnt_r >= cfg_r.retry_limit) begin
                        hs_r        <= HS_ACTIVE;
                        retry_cnt_r <= '0;
                    end else if (hs_done_w) begin
                        sw_req_o    <= 1'b1;
                        retry_cnt_r <= retry_cnt_r + 8'h01;
                    end
                end
                default: hs_r <= HS_OFFLINE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_master_o <= 1'b0;
            net_online_o <= 1'b0;
            out_data_o   <= '0;
        end else begin
            bus_master_o <= (hs_r == HS_ACTIVE) || (hs_r == HS_HOLDOVER);
            net_online_o <= (hs_r == HS_ACTIVE) || (hs_r == HS_HOLDOVER);
            // Host data only latched while connected: holdover replays last values
            if (host_data_vld_i && ctrl_r[CTRL_HOST_OK]) out_data_o <= host_data_i;
        end
    end

    a_holdover_ends: assert property (@(posedge clk_i) disable iff (rst_i)
        (hs_r == HS_HOLDOVER && hs_done_w && !ctrl_r[CTRL_HOST_OK]) |=> hs_r == HS_OFFLINE ##1 !net_online_o)
        else $error("holdover did not end offline");
    a_idle1_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        evt_i.tx_ack_rx |=> !tx_allow_o [*8])
        else $error("transmit allowed inside idle gap");
    a_idle2_value: assert property (@(posedge clk_i) disable iff (rst_i)
        idle2_w >= cfg_r.max_tsdr && idle2_w >= SYN_BITS + sm_w)
        else $error("second idle too short");
    a_tset_range: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_r.tset >= TSET_MIN && cfg_r.tset <= TSET_MAX)
        else $error("setup time out of range");
    a_retry_takeover: assert property (@(posedge clk_i) disable iff (rst_i)
        (hs_r == HS_STANDBY && ctrl_r[CTRL_STANDBY] && retry_cnt_r >= cfg_r.retry_limit)
        |=> hs_r == HS_ACTIVE ##1 bus_master_o)
        else $error("no takeover after retry limit");
    a_holdover_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (hs_r == HS_HOLDOVER && !ctrl_r[CTRL_HOST_OK]) |=> $stable(out_data_o))
        else $error("output data changed during holdover");
    a_req_standby: assert property (@(posedge clk_i) disable iff (rst_i)
        sw_req_o |-> $past(hs_r) == HS_STANDBY)
        else $error("switch request outside standby");
    a_rate_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_w && adr_i == REG_BITRATE && dat_i[3:0] < RATE_COUNT && dat_i[3:0] != rate_r)
        |=> cfg_r == rate_defaults(rate_r))
        else $error("defaults not reloaded on rate change");
endmodule
`default_nettype wire

// file: verification/fb_far_side.sv
// Far-side model: slave bus activity and partner master confirm
`timescale 1ns/1ps
`default_nettype none
module fb_far_side (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic sw_req_i,
    input  wire logic quiet_i,
    input  wire logic confirm_en_i,
    output logic      bus_active_o,
    output logic      sw_confirm_o
);
    logic [1:0] dly_r;
    // Partner is slow on purpose: confirm three cycles after the request
    always_ff @(posedge clk_i) begin
        dly_r        <= rst_i ? 2'h0 : {dly_r[0], sw_req_i & confirm_en_i};
        sw_confirm_o <= ~rst_i & dly_r[1];
    end
    // Slaves keep the line busy unless told to fall silent
    assign bus_active_o = ~quiet_i;
endmodule
`default_nettype wire

// file: verification/test_fb_timing_hot_standby.sv
// Self-checking bench for the timing and hot-standby core
`timescale 1ns/1ps
`default_nettype none
module test_fb_timing_hot_standby;
    import fb_timing_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, hvld = 1'b0;
    logic        quiet = 1'b0, cfm_en = 1'b0, ack, err, e, act, cfm, allow, tick, master, online, req;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, hdat = 32'h0, rdat, q, odat;
    logic [15:0] swd;
    bus_evt_type evt = '0;
    int          checks = 0, n_fail = 0, n;

    fb_timing_hot_standby #(.CYC_PER_MS(10)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
        .dat_o(rdat), .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .err_o(err),
        .evt_i(evt), .bus_active_i(act), .host_data_vld_i(hvld), .host_data_i(hdat),
        .sw_confirm_i(cfm), .tx_allow_o(allow), .cycle_tick_o(tick), .bus_master_o(master),
        .net_online_o(online), .sw_req_o(req), .out_data_o(odat), .slave_wdog_o(swd));
    fb_far_side far (.clk_i(clk_i), .rst_i(rst_i), .sw_req_i(req), .quiet_i(quiet),
        .confirm_en_i(cfm_en), .bus_active_o(act), .sw_confirm_o(cfm));

    always #4 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One classic cycle; waits for ack or err with no assumed latency
    task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
        adr <= a; we <= w; wdat <= d; cyc <= 1'b1; stb <= 1'b1;
        do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
        q = rdat; e = err;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rst_seq();
        rst_i <= 1'b1; repeat (8) @(posedge clk_i);
        rst_i <= 1'b0; @(posedge clk_i);
    endtask
    task automatic t_regs();
        acc(REG_IDLE1, 1'b0, 0); chk(q, 32'h25);
        acc(REG_IDLE2, 1'b0, 0); chk(q, 32'h3C);
        acc(REG_TSET, 1'b1, 32'h200); acc(REG_TSET, 1'b0, 0); chk(q, 32'h1EE);
        acc(REG_TSET, 1'b1, 5); acc(REG_TQUI, 1'b1, 3); acc(REG_MIN_TSDR, 1'b1, 32'h14);
        acc(REG_IDLE1, 1'b0, 0); chk(q, 32'h30);
        acc(REG_MAX_TSDR, 1'b1, 32'h28); acc(REG_IDLE2, 1'b0, 0); chk(q, 32'h30);
        acc(REG_CYCLE, 1'b1, 7); acc(REG_CYCLE, 1'b0, 0); chk(q, 7);
        acc(REG_SLV_SEL, 1'b1, 2); acc(REG_SLV_WDOG, 1'b0, 0); chk(q, 32'h64);
        chk(swd, 16'h0064);
        // Own value with the use-own flag set overrides the default
        acc(REG_SLV_WDOG, 1'b1, 32'h1_0123); acc(REG_SLV_WDOG, 1'b0, 0); chk(q, 32'h123);
        chk(swd, 16'h0123);
        acc(8'hFC, 1'b0, 0); chk(e, 1'b1);
    endtask
    task automatic t_rate();
        acc(REG_BITRATE, 1'b1, 7);
        acc(REG_TSET, 1'b0, 0); chk(q, 32'h10);
        acc(REG_MAX_TSDR, 1'b0, 0); chk(q, 32'h320);
        acc(REG_IDLE1, 1'b0, 0); chk(q, 32'h4C);
        acc(REG_RETRY, 1'b0, 0); chk(q, 32'h20);
    endtask
    // Gap after an event pulse, counted in clocks of four per bit
    task automatic gap(input logic unconf, input int bits);
        evt.tx_ack_rx <= ~unconf; evt.tx_unconf <= unconf; @(posedge clk_i);
        evt <= '0; repeat (2) @(posedge clk_i);
        chk(allow, 1'b0);
        for (n = 3; n < bits * 4 + 20 && allow !== 1'b1; n++) @(posedge clk_i);
        chk(n >= bits * 4 - 2 && n <= bits * 4 + 4, 1'b1);
    endtask
    task automatic t_hold();
        acc(REG_HOLDOVER, 1'b1, 3); acc(REG_CTRL, 1'b1, 6);
        hdat <= 32'hA5A5_1234; hvld <= 1'b1; @(posedge clk_i);
        hvld <= 1'b0;
        // Tick spacing of 3 ms at ten clocks per ms, measured after the new value is in use
        acc(REG_CYCLE, 1'b1, 3);
        for (n = 0; n < 300 && tick !== 1'b1; n++) @(posedge clk_i);
        @(posedge clk_i);
        for (n = 1; n < 300 && tick !== 1'b1; n++) @(posedge clk_i);
        chk(n, 30);
        gap(1'b0, 76);
        gap(1'b1, 800);
        acc(REG_CTRL, 1'b1, 4); repeat (20) @(posedge clk_i);
        chk(online, 1'b1);
        chk(odat, 32'hA5A5_1234);
        repeat (20) @(posedge clk_i);
        chk(online, 1'b0);
    endtask
    task automatic t_retry();
        rst_seq(); acc(REG_CMD_RATE, 1'b1, 2); acc(REG_RETRY, 1'b1, 1);
        acc(REG_RETRY, 1'b0, 0); chk(q, 5);
        // Standby with host and online set, so a takeover stays active
        acc(REG_CTRL, 1'b1, 7);
        for (n = 0; n < 300 && req !== 1'b1; n++) @(posedge clk_i);
        @(posedge clk_i);
        for (n = 1; n < 300 && req !== 1'b1; n++) @(posedge clk_i);
        chk(n, 20);
        chk(master, 1'b0);
        for (n = 0; n < 200 && master !== 1'b1; n++) @(posedge clk_i);
        chk(master, 1'b1);
    endtask
    task automatic t_takeover();
        rst_seq(); cfm_en <= 1'b1; acc(REG_CTRL, 1'b1, 7);
        for (n = 0; n < 300 && master !== 1'b1; n++) @(posedge clk_i);
        chk(master, 1'b1);
        rst_seq(); cfm_en <= 1'b0; quiet <= 1'b1;
        acc(REG_DEADTIME, 1'b1, 2); acc(REG_CTRL, 1'b1, 7); repeat (8) @(posedge clk_i);
        chk(master, 1'b0);
        for (n = 0; n < 40 && master !== 1'b1; n++) @(posedge clk_i);
        chk(master, 1'b1);
        // Standby entered two clocks after the write; 20 quiet clocks plus two register stages
        chk(n >= 12 && n <= 14, 1'b1);
    endtask
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #600000;
        n_fail++;
        end_of_test();
    end
    initial begin
        rst_seq();
        t_regs();
        t_rate();
        t_hold();
        t_retry();
        t_takeover();
        end_of_test();
    end
endmodule
`default_nettype wire
